// ---- cbge_pkg.sv ----
// Purpose: Constants for the greater-or-equal conditional branch unit
// Assumes: 32-bit instruction words and 32-bit addresses
// Notes:   Field positions of the immediate-format instruction word
package cbge_pkg;
	localparam int          CBGE_XLEN         = 32;
	localparam int          CBGE_IDX_W        = 5;
	localparam int          CBGE_OFS_W        = 16;
	localparam int          CBGE_OPC_W        = 6;
	localparam int          CBGE_SRC1_MSB     = 31;
	localparam int          CBGE_SRC1_LSB     = 27;
	localparam int          CBGE_SRC2_MSB     = 26;
	localparam int          CBGE_SRC2_LSB     = 22;
	localparam int          CBGE_OFS_MSB      = 21;
	localparam int          CBGE_OFS_LSB      = 6;
	localparam int          CBGE_OPC_MSB      = 5;
	localparam int          CBGE_OPC_LSB      = 0;
	localparam logic [5:0]  CBGE_OPC_GE_S     = 6'h0E;
	localparam logic [5:0]  CBGE_OPC_GE_U     = 6'h2E;
	localparam logic [31:0] CBGE_INSN_STEP    = 32'h0000_0004;
	localparam logic [31:0] CBGE_PC_RESET     = 32'h0000_0000;
	localparam logic [4:0]  CBGE_IDX_RESET    = 5'h00;
	localparam logic        CBGE_FLAG_RESET   = 1'h0;
	localparam logic        CBGE_SYNC_RESET   = 1'h0;
endpackage : cbge_pkg

// ---- cbge_branch_unit.sv ----
// Purpose: Decodes and resolves signed and unsigned greater-or-equal branches
// Assumes: Register file lies outside; operands arrive with the instruction
// Notes:   One instruction per cycle on issue_valid; results one cycle later
`timescale 1ns/1ps
`default_nettype none
module cbge_branch_unit #(
	parameter int XLEN  = cbge_pkg::CBGE_XLEN,
	parameter int IDX_W = cbge_pkg::CBGE_IDX_W,
	parameter int OFS_W = cbge_pkg::CBGE_OFS_W,
	parameter int OPC_W = cbge_pkg::CBGE_OPC_W
) (
	input  wire logic                                   sys_clk,
	input  wire logic                                   arst_n,
	input  wire logic                                   issue_valid,
	input  wire logic [cbge_pkg::CBGE_XLEN-1:0]         issue_insn,
	input  wire logic [cbge_pkg::CBGE_XLEN-1:0]         issue_pc,
	input  wire logic [cbge_pkg::CBGE_XLEN-1:0]         first_source_val,
	input  wire logic [cbge_pkg::CBGE_XLEN-1:0]         second_source_val,
	output logic [cbge_pkg::CBGE_IDX_W-1:0]             first_source_reg,
	output logic [cbge_pkg::CBGE_IDX_W-1:0]             second_source_reg,
	output logic                                        br_done,
	output logic                                        br_taken,
	output logic                                        br_unknown_op,
	output logic [cbge_pkg::CBGE_XLEN-1:0]              next_pc
);
	import cbge_pkg::*;

	// Refuse widths, field placements and opcode codes that the fixed field layout cannot serve
	if (XLEN != CBGE_XLEN) begin : g_chk_xlen
		$error("cbge_branch_unit needs XLEN equal to the instruction word width");
	end
	if (IDX_W != CBGE_SRC1_MSB - CBGE_SRC1_LSB + 1) begin : g_chk_src1
		$error("cbge_branch_unit needs IDX_W equal to the first index field");
	end
	if (IDX_W != CBGE_SRC2_MSB - CBGE_SRC2_LSB + 1) begin : g_chk_src2
		$error("cbge_branch_unit needs IDX_W equal to the second index field");
	end
	if (IDX_W != CBGE_IDX_W) begin : g_chk_idx
		$error("cbge_branch_unit needs IDX_W equal to the index port width");
	end
	if (OFS_W != CBGE_OFS_MSB - CBGE_OFS_LSB + 1) begin : g_chk_ofs
		$error("cbge_branch_unit needs OFS_W equal to the offset field");
	end
	if (OFS_W >= XLEN) begin : g_chk_ext
		$error("cbge_branch_unit needs OFS_W below XLEN for sign extension");
	end
	if (OPC_W != CBGE_OPC_MSB - CBGE_OPC_LSB + 1) begin : g_chk_opc
		$error("cbge_branch_unit needs OPC_W equal to the opcode field");
	end
	if (CBGE_SRC1_LSB != CBGE_SRC2_MSB + 1) begin : g_chk_pack1
		$error("cbge_branch_unit needs the index fields side by side");
	end
	if (CBGE_SRC2_LSB != CBGE_OFS_MSB + 1) begin : g_chk_pack2
		$error("cbge_branch_unit needs the offset right below the second index");
	end
	if (CBGE_OFS_LSB != CBGE_OPC_MSB + 1) begin : g_chk_pack3
		$error("cbge_branch_unit needs the opcode right below the offset");
	end
	if (CBGE_OPC_GE_S == CBGE_OPC_GE_U) begin : g_chk_codes
		$error("cbge_branch_unit needs distinct signed and unsigned codes");
	end

	// Reset release flip-flops
	logic                   rst_meta_r;
	logic                   rst_sync_n_r;

	// Decoded fields of the offered word
	logic [IDX_W-1:0]       src1_idx;
	logic [IDX_W-1:0]       src2_idx;
	logic [OFS_W-1:0]       branch_offset_field;
	logic [OPC_W-1:0]       opcode;
	logic                   is_ge_s;
	logic                   is_ge_u;
	logic                   is_ge_any;

	// Operand comparison and target arithmetic
	logic signed [XLEN-1:0] first_signed;
	logic signed [XLEN-1:0] second_signed;
	logic                   ge_signed;
	logic                   ge_unsigned;
	logic                   take;
	logic [XLEN-1:0]        seq_pc;
	logic [XLEN-1:0]        ofs_ext;
	logic [XLEN-1:0]        tgt_pc;
	logic [XLEN-1:0]        branch_pc;

	// Result registers and their next values
	logic                   done_r;
	logic                   done_nxt;
	logic                   taken_r;
	logic                   taken_nxt;
	logic                   unknown_r;
	logic                   unknown_nxt;
	logic [XLEN-1:0]        pc_r;
	logic [XLEN-1:0]        pc_nxt;
	logic [IDX_W-1:0]       src1_r;
	logic [IDX_W-1:0]       src1_nxt;
	logic [IDX_W-1:0]       src2_r;
	logic [IDX_W-1:0]       src2_nxt;

	// First reset release flip-flop
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_r <= CBGE_SYNC_RESET;
		end else begin
			rst_meta_r <= ~CBGE_SYNC_RESET;
		end
	end

	// Second release flip-flop; only it feeds the rest of the block
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_n_r <= CBGE_SYNC_RESET;
		end else begin
			rst_sync_n_r <= rst_meta_r;
		end
	end

	// Field decode of the immediate-format word
	assign src1_idx            = issue_insn[CBGE_SRC1_MSB:CBGE_SRC1_LSB];
	assign src2_idx            = issue_insn[CBGE_SRC2_MSB:CBGE_SRC2_LSB];
	assign branch_offset_field = issue_insn[CBGE_OFS_MSB:CBGE_OFS_LSB];
	assign opcode              = issue_insn[CBGE_OPC_MSB:CBGE_OPC_LSB];

	// Opcode match; every other code is reported as unknown
	assign is_ge_s   = (opcode == CBGE_OPC_GE_S);
	assign is_ge_u   = (opcode == CBGE_OPC_GE_U);
	assign is_ge_any = is_ge_s | is_ge_u;

	// Comparisons; greater-than forms reach the less-than unit, not this one
	assign first_signed  = first_source_val;
	assign second_signed = second_source_val;
	assign ge_signed     = (first_signed >= second_signed);
	assign ge_unsigned   = (first_source_val >= second_source_val);
	assign take          = (is_ge_s & ge_signed) | (is_ge_u & ge_unsigned);

	// Target counts from the following word; offset low bits used as given
	assign seq_pc    = issue_pc + XLEN'(CBGE_INSN_STEP);
	assign ofs_ext   = {{(XLEN - OFS_W){branch_offset_field[OFS_W-1]}},
		branch_offset_field};
	assign tgt_pc    = seq_pc + ofs_ext;
	assign branch_pc = take ? tgt_pc : seq_pc;

	// Next values: pulses follow each issue, held fields change only on issue
	assign done_nxt    = issue_valid & is_ge_any;
	assign taken_nxt   = issue_valid & take;
	assign unknown_nxt = issue_valid & ~is_ge_any;
	assign pc_nxt      = issue_valid ? branch_pc : pc_r;
	assign src1_nxt    = issue_valid ? src1_idx : src1_r;
	assign src2_nxt    = issue_valid ? src2_idx : src2_r;

	// Resolved pulse
	always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			done_r <= CBGE_FLAG_RESET;
		end else begin
			done_r <= done_nxt;
		end
	end

	// Taken pulse
	always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			taken_r <= CBGE_FLAG_RESET;
		end else begin
			taken_r <= taken_nxt;
		end
	end

	// Unknown opcode pulse
	always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			unknown_r <= CBGE_FLAG_RESET;
		end else begin
			unknown_r <= unknown_nxt;
		end
	end

	// Program counter, held until the next issue
	always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			pc_r <= CBGE_PC_RESET;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// First register index, held until the next issue
	always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			src1_r <= CBGE_IDX_RESET;
		end else begin
			src1_r <= src1_nxt;
		end
	end

	// Second register index, held until the next issue
	always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			src2_r <= CBGE_IDX_RESET;
		end else begin
			src2_r <= src2_nxt;
		end
	end

	// Outputs come straight from the registers
	assign br_done           = done_r;
	assign br_taken          = taken_r;
	assign br_unknown_op     = unknown_r;
	assign next_pc           = pc_r;
	assign first_source_reg  = src1_r;
	assign second_source_reg = src2_r;
endmodule // cbge_branch_unit
`default_nettype wire

// ---- cbge_properties.sv ----
// Purpose: Assertions for the ge branch unit
// Assumes: One clock, reset active low
// Notes:   Attached by bind
`timescale 1ns/1ps
`default_nettype none
module cbge_checker (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        issue_valid,
	input wire logic        br_done,
	input wire logic        br_taken,
	input wire logic        br_unknown_op,
	input wire logic [31:0] issue_insn,
	input wire logic [31:0] issue_pc,
	input wire logic [31:0] first_source_val,
	input wire logic [31:0] second_source_val,
	input wire logic [31:0] next_pc,
	input wire logic [4:0]  first_source_reg,
	input wire logic [4:0]  second_source_reg
);
	// Expected outcome of the offered word
	wire [31:0] seq = issue_pc + 32'h4;
	wire [31:0] tgt = seq + {{16{issue_insn[21]}}, issue_insn[21:6]};
	wire        ges = $signed(first_source_val) >= $signed(second_source_val);
	wire        geu = first_source_val >= second_source_val;
	wire        v_s = issue_valid && issue_insn[5:0] == 6'h0E;
	wire        v_u = issue_valid && issue_insn[5:0] == 6'h2E;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_signed_taken: assert property (v_s && ges |=>
		br_done && br_taken && next_pc == $past(tgt))
		else $error("signed taken wrong");
	a_signed_fall: assert property (v_s && !ges |=>
		br_done && !br_taken && next_pc == $past(seq))
		else $error("signed fall wrong");
	a_unsigned_taken: assert property (v_u && geu |=>
		br_done && br_taken && next_pc == $past(tgt))
		else $error("unsigned taken wrong");
	a_unsigned_fall: assert property (v_u && !geu |=>
		br_done && !br_taken && next_pc == $past(seq))
		else $error("unsigned fall wrong");
	a_index_fields: assert property (issue_valid |=>
		{first_source_reg, second_source_reg} == $past(issue_insn[31:22]))
		else $error("index fields wrong");
	a_unknown_flag: assert property (issue_valid && !v_s && !v_u |=>
		br_unknown_op && !br_done && !br_taken && next_pc == $past(seq))
		else $error("unknown opcode handling wrong");
	a_idle_quiet: assert property (!issue_valid |=>
		!br_done && !br_taken && !br_unknown_op && $stable(next_pc))
		else $error("idle cycle changed results");
	c_signed: cover property (v_s && ges);
	c_unsigned: cover property (v_u && !geu);
	c_equal: cover property (v_u && first_source_val == second_source_val);
	c_unknown: cover property (issue_valid && !v_s && !v_u);
endmodule // cbge_checker
bind cbge_branch_unit cbge_checker i_cbge_checker (
	.sys_clk           (sys_clk),
	.arst_n            (arst_n),
	.issue_valid       (issue_valid),
	.br_done           (br_done),
	.br_taken          (br_taken),
	.br_unknown_op     (br_unknown_op),
	.issue_insn        (issue_insn),
	.issue_pc          (issue_pc),
	.first_source_val  (first_source_val),
	.second_source_val (second_source_val),
	.next_pc           (next_pc),
	.first_source_reg  (first_source_reg),
	.second_source_reg (second_source_reg)
);
`default_nettype wire

// ---- conditional_branch_ge_unit_tb.sv ----
// Purpose: Random back-to-back branches against a model
// Assumes: Results one cycle after issue
// Notes:   Expectations queued, checked when a result pulses
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_ge_unit_tb;
	logic        sys_clk = 0, arst_n = 0, issue_valid = 0, br_done, br_taken, br_unknown_op;
	logic [31:0] issue_insn = 0, issue_pc = 0, first_source_val = 0, second_source_val = 0, next_pc;
	logic [4:0]  first_source_reg, second_source_reg;
	logic [44:0] exp_q[$];
	int          err_count = 0, comparisons = 0;
	always #2 sys_clk = ~sys_clk;
	cbge_branch_unit i_cbge_branch_unit (
		.sys_clk           (sys_clk),
		.arst_n            (arst_n),
		.issue_valid       (issue_valid),
		.issue_insn        (issue_insn),
		.issue_pc          (issue_pc),
		.first_source_val  (first_source_val),
		.second_source_val (second_source_val),
		.first_source_reg  (first_source_reg),
		.second_source_reg (second_source_reg),
		.br_done           (br_done),
		.br_taken          (br_taken),
		.br_unknown_op     (br_unknown_op),
		.next_pc           (next_pc)
	);
	task automatic check(string n, logic [44:0] s, logic [44:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watcher takes the oldest note per result; a result with no note is a mismatch
	always @(posedge sys_clk) begin
		#1;
		if (arst_n && (br_done | br_unknown_op) !== 1'b0) begin
			if (exp_q.size() != 0) begin
				check("result", {br_done, br_taken, br_unknown_op, first_source_reg,
					second_source_reg, next_pc}, exp_q.pop_front());
			end else begin
				check("unexpected", {br_done, br_taken, br_unknown_op, 42'h0}, 45'h0);
			end
		end
	end
	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		print_verdict;
	end
	// Issues a burst with an idle cycle every seventh slot and notes expectations
	task automatic run_burst(int n);
		logic        t;
		logic        g;
		logic        idle_prev = 1'b0;
		logic [31:0] last_pc = 32'h0;
		logic [31:0] swap;
		for (int i = 0; i < n; i++) begin
			#1;
			if (idle_prev) check("idle", 45'({br_done, br_taken, br_unknown_op, next_pc}), 45'(last_pc));
			issue_valid = (i % 7 != 6);
			issue_insn = {$urandom} & 32'hFFFF_FF3F;
			issue_insn[5:0] = (i % 3 == 0) ? 6'h0E : (i % 3 == 1) ? 6'h2E : 6'($urandom);
			issue_pc = {$urandom} & 32'hFFFF_FFFC;
			first_source_val = $urandom;
			second_source_val = (i % 4) ? $urandom : first_source_val;
			if (i % 10 == 9) begin
				issue_insn[5:0] = 6'h16;
				swap = first_source_val;
				first_source_val = second_source_val;
				second_source_val = swap;
			end
			g = issue_insn[5:0] == 6'h0E || issue_insn[5:0] == 6'h2E;
			t = issue_insn[5] ? first_source_val >= second_source_val :
				$signed(first_source_val) >= $signed(second_source_val);
			t = t && g;
			if (issue_valid) begin
				last_pc = issue_pc + 32'h4 + (t ? {{16{issue_insn[21]}}, issue_insn[21:6]} : 32'h0);
				exp_q.push_back({g, t, !g, issue_insn[31:22], last_pc});
			end
			idle_prev = !issue_valid;
			@(posedge sys_clk);
		end
		#1 issue_valid = 0;
		repeat (3) @(posedge sys_clk);
	endtask
	// Driver: reset, burst, reset in mid-run, second burst
	initial begin
		void'($urandom(32'hC1DE52AF));
		repeat (2) @(posedge sys_clk);
		#1 arst_n = 1;
		repeat (3) @(posedge sys_clk);
		run_burst(400);
		#1 arst_n = 0;
		#1 check("reset", {br_done, br_taken, br_unknown_op, first_source_reg,
			second_source_reg, next_pc}, 45'h0);
		repeat (2) @(posedge sys_clk);
		#1 arst_n = 1;
		repeat (3) @(posedge sys_clk);
		run_burst(200);
		check("pending", 45'(exp_q.size()), 45'h0);
		print_verdict;
	end
endmodule // conditional_branch_ge_unit_tb
`default_nettype wire
